// ===== rtl/dpskip.sv
// Defect pad skip on the read side of a disk channel adapter.
// Assumes the drive read path delivers parcels in the clk_i domain with a
// valid strobe and that the sector setup is latched by a start pulse.
// The receiver behind out_o may stall at any time; the two-entry buffer
// absorbs that without losing a parcel.
// Setup flags arrive already classified; this block only obeys them.
// Timing, one clock edge at a time:
//   start_i taken in idle; busy_o rises on the next edge, drv_ready_o with it unless that is the match cycle or both slots are full.
//   Each parcel taken in a run is counted and goes to the buffer.
//   The match cycle shuts drv_ready_o for one cycle and raises
//   pad_active_o; the next nine parcels taken are dropped, each one
//   followed by a one-cycle reject_o.
//   The last parcel moves the sequencer to its done state and busy_o
//   falls with it; done_o pulses on the edge after.
//
// Limitations:
//   A new start_i is ignored until the sequencer is back in idle.
//   A last flag inside the pad ends the read with the pad cut short.
//   The flaw classes arrive as setup flags; no flaw position is checked.
`timescale 1ns/10ps
`include "dpskip_defs.svh"

module dpskip #(
    parameter int PAD_PARCELS = 9
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  start_i,
    input  dpskip_pkg::dps_setup_t     setup_i,
    input  dpskip_pkg::dps_beat_t      drv_i,
    output logic                       drv_ready_o,
    output dpskip_pkg::dps_beat_t      out_o,
    input  wire logic                  out_ready_i,
    output logic                       busy_o,
    output logic                       pad_active_o,
    output logic                       done_o,
    output logic                       reject_o
);
    import dpskip_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Parameter checked against the legal range and unhideable classes.
    // An unhideable sector never arms the pad: the whole field passes
    // and the sector is left for software to retire.
    function automatic logic pad_legal(input dps_setup_t s);
        pad_legal = !s.unhideable &&
                    !s.id_flaw &&
                    (s.defect_param <= `DPS_PARAM_MAX);
    endfunction

    // Parcel counter step; wraps only past any legal field length
    function automatic dps_cnt_t inc(input dps_cnt_t v);
        inc = v + 13'h0001;
    endfunction

    // Defect counter step, used once per dropped parcel
    function automatic dps_cnt_t dec(input dps_cnt_t v);
        dec = v - 13'h0001;
    endfunction

    // Pad position reached: the parcel count equals the stored parameter
    // while the pad is still armed.  Disarming at the match keeps the
    // frozen count from matching a second time after the pad.
    function automatic logic is_match(input logic     armed,
                                      input dps_cnt_t cnt,
                                      input dps_cnt_t param);
        is_match = armed && (cnt == param);
    endfunction

    // Drive-side ready for a given state: open in the pad, open in a run
    // with a free slot, and shut on the match cycle so that no parcel is
    // taken while the counters swap over.
    function automatic logic ready_for(input dps_state_t s,
                                       input logic [1:0] fill,
                                       input logic       match);
        if (s == DPS_PAD) begin
            ready_for = 1'b1;
        end else if (s == DPS_RUN) begin
            ready_for = (fill != 2'd2) && !match;
        end else begin
            ready_for = 1'b0;
        end
    endfunction

    // Physical length limit of the field: the pad adds its bytes to the
    // field, which then runs on into the spare region.
    function automatic dps_cnt_t field_limit(input logic has_pad);
        if (has_pad) begin
            field_limit = `DPS_PADDED_BYTES;
        end else begin
            field_limit = `DPS_FIELD_BYTES;
        end
    endfunction

    // Pushed parcel lands in slot 0 when that slot is free after a pop
    function automatic logic push_to_head(input logic [1:0] fill,
                                          input logic       pop);
        push_to_head = (fill == 2'd0) || ((fill == 2'd1) && pop);
    endfunction

    dps_state_s_t st_ff;
    dps_state_s_t nxt_st;
    logic         take_in;
    logic         take_out;
    logic         accept;
    logic         match_now;
    logic         match_next;
    logic         end_of_field;
    dps_cnt_t     bytes_next;

    // ------------------------------------------------------------
    // Buffer handshakes
    // ------------------------------------------------------------
    // Ready stays low in a run once both slots are full, so a stalled receiver
    // pushes back on the drive path instead of dropping a parcel.
    // Both strobes read registered outputs, so no path runs from an
    // input to the ready seen by the drive.
    assign take_in   = drv_i.valid && drv_ready_o;
    assign take_out  = out_o.valid && out_ready_i;

    // ------------------------------------------------------------
    // Pad position
    // ------------------------------------------------------------
    // Pad position of the present cycle; the sequencer branches on it
    assign match_now = is_match(st_ff.padded, st_ff.parcel_cnt,
                                st_ff.defect_param);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // One pass computes the whole next state; every field not named
    // below keeps its value, which is what freezes the parcel counter
    // through the pad.
    always_comb begin
        nxt_st       = st_ff;
        accept       = 1'b0;
        match_next   = 1'b0;
        end_of_field = 1'b0;
        bytes_next   = st_ff.byte_cnt;
        nxt_st.done  = 1'b0;
        case (st_ff.state)
            DPS_IDLE: begin
                // An illegal or unhideable setup stores the no-flaw
                // value, so the count never matches and every parcel passes
                if (start_i) begin
                    nxt_st.defect_param = pad_legal(setup_i) ?
                        setup_i.defect_param : `DPS_PARAM_MAX;
                    nxt_st.padded     = pad_legal(setup_i) &&
                        (setup_i.defect_param != `DPS_PARAM_MAX);
                    nxt_st.parcel_cnt = '0;
                    nxt_st.byte_cnt   = '0;
                    nxt_st.defect_cnt = '0;
                    nxt_st.state      = DPS_RUN;
                end
            end
            DPS_RUN: begin
                // The match cycle takes no parcel: ready was shut for it,
                // and the pad is disarmed so the frozen count cannot
                // match again once the repeats have passed.
                if (match_now) begin
                    nxt_st.defect_cnt = dps_cnt_t'(PAD_PARCELS);
                    nxt_st.padded     = 1'b0;
                    nxt_st.state      = DPS_PAD;
                end else if (take_in) begin
                    accept            = 1'b1;
                    nxt_st.parcel_cnt = inc(st_ff.parcel_cnt);
                    if (drv_i.last) begin
                        nxt_st.state = DPS_DONE;
                    end
                end
            end
            DPS_PAD: begin
                // Parcel counter frozen; the repeats that the writer put
                // down over the flaw are dropped here
                if (take_in) begin
                    nxt_st.defect_cnt = dec(st_ff.defect_cnt);
                    if (st_ff.defect_cnt == 13'h0001) begin
                        nxt_st.state = DPS_RUN;
                    end
                    if (drv_i.last) begin
                        nxt_st.state = DPS_DONE;
                    end
                end
            end
            // One-cycle stop before idle, so done_o is a registered pulse
            DPS_DONE: begin
                nxt_st.done  = 1'b1;
                nxt_st.state = DPS_IDLE;
            end
            default: nxt_st.state = DPS_IDLE;
        endcase

        // ------------------------------------------------------------
        // Field length
        // ------------------------------------------------------------
        // Physical bytes seen; 4096 plain or 4114 with the pad, the
        // spare region carrying the overflow in the padded case
        if (take_in) begin
            bytes_next      = st_ff.byte_cnt + 13'h0002;
            nxt_st.byte_cnt = bytes_next;
        end

        // Field length guard: a drive that never flags the last parcel
        // still ends the read once the physical field is used up, so the
        // sequencer cannot hang in a run.  A sector with a pad may run
        // into the spare region by the pad's length.
        end_of_field = take_in &&
                       (bytes_next >= field_limit(
                           st_ff.defect_param != `DPS_PARAM_MAX));
        if (end_of_field) begin
            nxt_st.state = DPS_DONE;
        end

        // ------------------------------------------------------------
        // Buffer
        // ------------------------------------------------------------

        // Two-entry buffer: pop first, then push to the free slot.
        // A pop and a push in one cycle keep the fill level, so a
        // receiver that is always ready sees one parcel per cycle.
        if (take_out) begin
            nxt_st.buf0 = st_ff.buf1;
        end
        if (accept) begin
            if (push_to_head(st_ff.fill, take_out)) begin
                nxt_st.buf0 = '{data: drv_i.data, last: drv_i.last};
            end else begin
                nxt_st.buf1 = '{data: drv_i.data, last: drv_i.last};
            end
        end
        nxt_st.fill = st_ff.fill + {1'b0, accept} - {1'b0, take_out};

        nxt_st.busy       = (nxt_st.state == DPS_RUN) ||
                            (nxt_st.state == DPS_PAD);
        nxt_st.pad_active = (nxt_st.state == DPS_PAD);
        nxt_st.reject     = (st_ff.state == DPS_PAD) && take_in;

        // ------------------------------------------------------------
        // Registered handshakes
        // ------------------------------------------------------------
        // Handshake outputs are worked out one cycle ahead from the next
        // state, so the ports come straight from flip-flops.  The match
        // of the next cycle is found from the next counters alone.
        match_next       = is_match(nxt_st.padded, nxt_st.parcel_cnt,
                                    nxt_st.defect_param);
        nxt_st.drv_ready = ready_for(nxt_st.state, nxt_st.fill,
                                     match_next);
        nxt_st.out_valid = (nxt_st.fill != 2'd0);
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Reset clears every field, which leaves all ports low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every port is a field of the state register.  Ready is held low
    // outside a read so no stray parcel is counted, and low on the match
    // cycle so the counters can swap over.
    assign drv_ready_o  = st_ff.drv_ready;
    assign out_o        = '{valid: st_ff.out_valid,
                            data:  st_ff.buf0.data,
                            last:  st_ff.buf0.last};
    assign busy_o       = st_ff.busy;
    assign pad_active_o = st_ff.pad_active;
    assign done_o       = st_ff.done;
    assign reject_o     = st_ff.reject;

endmodule

// ===== rtl/dpskip_defs.svh
// Constants for the defect pad skip block: widths, counts and limits.
// Included by the package and the design; definitions only.
`ifndef DPSKIP_DEFS_SVH
`define DPSKIP_DEFS_SVH

`define DPS_PARCEL_W      16
`define DPS_CNT_W         13
`define DPS_PAD_PARCELS   13'h0009
`define DPS_PAD_BYTES     18
`define DPS_FIELD_BYTES   13'h1000
`define DPS_PADDED_BYTES  13'h1012
`define DPS_PARAM_MAX     13'h1004
`define DPS_LEAD_BYTES    13'h0008
`define DPS_FLAW_MAX_BITS 8'h20

`endif

// ===== rtl/dpskip_pkg.sv
// Types shared by the defect pad skip block.
// Assumes dpskip_defs.svh is on the include path.
`include "dpskip_defs.svh"

package dpskip_pkg;

    typedef logic [`DPS_PARCEL_W-1:0] dps_parcel_t;
    typedef logic [`DPS_CNT_W-1:0]    dps_cnt_t;

    // Sequencer states
    typedef enum logic [1:0] {
        DPS_IDLE = 2'b00,
        DPS_RUN  = 2'b01,
        DPS_PAD  = 2'b10,
        DPS_DONE = 2'b11
    } dps_state_t;

    // Sector setup taken from the identification field
    typedef struct packed {
        dps_cnt_t defect_param;
        logic     unhideable;
        logic     id_flaw;
    } dps_setup_t;

    // One parcel on a stream
    typedef struct packed {
        logic        valid;
        dps_parcel_t data;
        logic        last;
    } dps_beat_t;

    // Buffer entry
    typedef struct packed {
        dps_parcel_t data;
        logic        last;
    } dps_entry_t;

    // Whole state of the block
    typedef struct packed {
        dps_state_t  state;
        dps_cnt_t    defect_param;
        dps_cnt_t    parcel_cnt;
        dps_cnt_t    defect_cnt;
        dps_cnt_t    byte_cnt;
        logic        padded;
        dps_entry_t  buf0;
        dps_entry_t  buf1;
        logic [1:0]  fill;
        logic        busy;
        logic        pad_active;
        logic        done;
        logic        reject;
        logic        drv_ready;
        logic        out_valid;
    } dps_state_s_t;

endpackage

// ===== tb/dps_chk_assertions.sv
// Port checker for the defect pad skip block.
// Assumes one clock domain; bound to dpskip at the foot.
`timescale 1ns/10ps
`include "dpskip_defs.svh"
module dps_chk_assertions (
    input wire logic                  clk_i,
    input wire logic                  rst_n_i,
    input wire logic                  start_i,
    input dpskip_pkg::dps_setup_t     setup_i,
    input dpskip_pkg::dps_beat_t      drv_i,
    input wire logic                  drv_ready_o,
    input dpskip_pkg::dps_beat_t      out_o,
    input wire logic                  out_ready_i,
    input wire logic                  busy_o,
    input wire logic                  pad_active_o,
    input wire logic                  done_o,
    input wire logic                  reject_o
);
    logic nopad_ff;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // Remember a sector that must never see the pad skipped
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) nopad_ff <= 1'b0;
        else if (start_i && !busy_o) nopad_ff <= setup_i.unhideable |
            setup_i.id_flaw | (setup_i.defect_param >= `DPS_PARAM_MAX);
    end
    chk_start_busy: assert property (start_i && !busy_o |=> busy_o)
        else $error("read did not start");
    chk_ready_busy: assert property (drv_ready_o |-> busy_o)
        else $error("parcel taken outside a read");
    chk_out_hold: assert property (out_o.valid && !out_ready_i |=>
        out_o.valid && $stable(out_o.data)) else $error("output dropped");
    chk_pad_reject: assert property (pad_active_o && drv_i.valid &&
        drv_ready_o |=> reject_o) else $error("pad parcel not rejected");
    chk_no_reject: assert property (!pad_active_o |=> !reject_o)
        else $error("parcel rejected outside pad");
    chk_pad_span: assert property ($rose(pad_active_o) |->
        pad_active_o[*8]) else $error("pad window too short");
    chk_done_pulse: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    chk_no_pad: assert property (nopad_ff |-> !pad_active_o)
        else $error("pad skipped on unpadded sector");
    chk_match_shut: assert property ($rose(pad_active_o) |->
        !$past(drv_ready_o)) else $error("parcel taken on match cycle");
endmodule
bind dpskip dps_chk_assertions i_dps_chk_assertions (.*);

// ===== tb/dps_drive_model.sv
// Drive read path model: sends a sector, with a nine-parcel pad inside.
// Assumes the bench gives length, pad position and stalls.
`timescale 1ns/10ps
module dps_drive_model import dpskip_pkg::*; (
    input wire logic  clk_i,
    input wire logic  rst_n_i,
    input wire logic  start_i,
    input wire logic  stall_i,
    input wire logic  pad_i,
    input int         n_i,
    input int         param_i,
    input wire logic  drv_ready_i,
    output dps_beat_t drv_o
);
    int p, tot, q;
    // Physical parcel x; the pad repeats the previous word nine times
    function automatic dps_parcel_t phys(int x);
        if (pad_i && x >= param_i && x < param_i + 9) x = param_i - 1;
        else if (pad_i && x >= param_i + 9) x = x - 9;
        return 16'(x * 945 ^ 23130);
    endfunction
    // Hold a parcel until taken; idle data toggles so stale words show
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            p <= 0;
            tot <= 0;
            drv_o <= '0;
        end else if (start_i) begin
            p <= 0;
            tot <= n_i + (pad_i ? 9 : 0);
            drv_o.valid <= 1'b0;
        end else begin
            q = p + int'(drv_o.valid && drv_ready_i);
            p <= q;
            if (!drv_o.valid || drv_ready_i) begin
                if (q < tot && !stall_i) drv_o <= '{1'b1, phys(q), q == tot - 1};
                else drv_o <= '{1'b0, ~drv_o.data, ~drv_o.last};
            end
        end
    end
endmodule

// ===== tb/tb.sv
// Self-checking bench for dpskip with a drive model at its input.
// Assumes dpskip_pkg is compiled first.
`timescale 1ns/10ps
module tb;
    import dpskip_pkg::*;
    logic clk_i = 0, rst_n_i = 0, start_i = 0, out_ready_i = 0;
    logic stall = 0, slow = 0, pad = 0;
    logic drv_ready_o, busy_o, pad_active_o, done_o, reject_o;
    dps_setup_t setup_i = '0;
    dps_beat_t  drv_i, out_o;
    int seed = 52277, fails = 0, checks_done = 0;
    int k = 0, rej = 0, dn = 0, n = 0, param = 0;
    always #10 clk_i = ~clk_i;
    dpskip i_dpskip (.clk_i, .rst_n_i, .start_i, .setup_i, .drv_i,
        .drv_ready_o, .out_o, .out_ready_i, .busy_o, .pad_active_o,
        .done_o, .reject_o);
    dps_drive_model i_dps_drive_model (.clk_i, .rst_n_i, .start_i,
        .stall_i(stall), .pad_i(pad), .n_i(n), .param_i(param),
        .drv_ready_i(drv_ready_o), .drv_o(drv_i));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("checks=%0d mismatches=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Receiver stalls at random; every word must arrive in order
    always @(posedge clk_i) begin
        out_ready_i <= slow ? 1'($random(seed)) : 1'b1;
        stall <= slow ? 1'($random(seed)) : 1'b0;
        if (out_o.valid && out_ready_i) begin
            check(out_o.data, 16'(k * 945 ^ 23130));
            check(16'(out_o.last), 16'(k == n - 1));
            k++;
        end
        rej += int'(reject_o);
        dn += int'(done_o);
    end
    task run(int nn, int pm, logic u, logic f, logic s);
        int w;
        @(posedge clk_i);
        n <= nn;
        param <= pm;
        slow <= s;
        k <= 0;
        rej <= 0;
        dn <= 0;
        pad <= !u && !f && pm < nn;
        setup_i <= '{pm[12:0], u, f};
        start_i <= 1'b1;
        @(posedge clk_i);
        start_i <= 1'b0;
        for (w = 0; w < 30000 && (dn == 0 || k < n); w++) @(posedge clk_i);
        check(16'(k), 16'(nn));
        check(16'(rej), (pad ? 16'h0009 : 16'h0000));
        check(16'(dn), 16'h0001);
        $display("test n=%0d param=%0d ended", nn, pm);
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        run(40, 5, 0, 0, 0);
        run(40, 0, 0, 0, 1);
        run(40, 5, 1, 0, 0);
        run(40, 5, 0, 1, 1);
        run(40, 4100, 0, 0, 0);
        run(2048, 2047, 0, 0, 1);
        repeat (4) run(20 + $unsigned($random(seed)) % 40,
            $unsigned($random(seed)) % 20, 0, 0, 1'($random(seed)));
        stop_test;
    end
    // Watchdog well past the expected run length
    initial begin
        #1600000;
        fails++;
        stop_test;
    end
endmodule
